// >>> inc/adc_serial_pkg.sv
// constants, codes and state encoding for the serial converter control logic
// assumes a 25 MHz system clock and a host-driven serial clock on the link side
// Functional notes
// - power-mode code 00 auto power-down, 10 internal clock, 01 reserved, 11 external clock.
// - control and result bits always move on the host serial clock.
// - a new clock mode applies only from the conversion after the byte carrying it.
// - code 00 keeps whichever clock mode was active.
// - auto power-down after each conversion, full power at next start, no delay.
// - external mode busy is high one serial clock after the last control bit.
// - external mode puts sixteen bit decisions on the next sixteen falling edges, MSB first.
// - next control byte may overlap the LSB, 24 clocks per conversion.
// - in 32-clock framing the trailing clocks shift out zeros.
// - external mode chip select high floats busy and data; next select drives busy low.
// - internal mode converts on its own clock; readout at any serial rate.
// - internal mode busy low during conversion, high after, low for at most 8 us.
// - internal result stays in a register until read.
// - select low at completion: MSB on next falling edge, then result_low_bits; the code puts the MSB on the falling edge after the third serial clock rise.
// - select high at completion: data stays floating until select goes low.
// - select may rise during internal conversion; conversion still completes.
// - internal mode keeps busy driven while select is high.
// - results are unsigned straight binary.
// - serial input ignored until a high start bit; fields follow in fixed order.
// - acquisition starts once the mux is known; hold three clocks later, then 16 clocks.
package adc_serial_pkg;
   localparam int RESULT_BITS = 16;
   localparam int CNT_W = 5;
   localparam logic [1:0] PM_AUTO_PD = 2'h0;
   localparam logic [1:0] PM_RESERVED = 2'h1;
   localparam logic [1:0] PM_INT_CLK = 2'h2;
   localparam logic [1:0] PM_EXT_CLK = 2'h3;
   // link-side bit counts, after the start bit has counted as one
   localparam logic [CNT_W-1:0] CNT_START = 5'h01;
   localparam logic [CNT_W-1:0] CNT_CHAN_DONE = 5'h03;
   localparam logic [CNT_W-1:0] CNT_ACQ_START = 5'h04;
   localparam logic [CNT_W-1:0] CNT_SGL_BIT = 5'h05;
   localparam logic [CNT_W-1:0] CNT_BYTE_DONE = 5'h07;
   localparam logic [CNT_W-1:0] CNT_LAST_SHIFT = 5'h0f;
   localparam logic [CNT_W-1:0] CNT_RESULT_DONE = 5'h10;
   // internal conversion timing
   localparam int CLK_HZ = 25_000_000;
   localparam int MAX_BUSY_NS = 8000;
   localparam int MAX_BUSY_CYCLES = (MAX_BUSY_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int INT_BIT_CYCLES = 10;
   localparam int INT_CONV_CYCLES = INT_BIT_CYCLES * RESULT_BITS;
   localparam int CONV_CNT_W = $clog2(INT_CONV_CYCLES + 1);
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_CTRL = 3'h1,
      PH_CONV = 3'h2,
      PH_WAIT = 3'h3,
      PH_READ = 3'h4
   } link_phase_t;
endpackage : adc_serial_pkg

// >>> inc/sync_if.sv
// carries a signal group into a two-flop synchroniser and back out
// assumes the raw bits are independent levels or handshake toggles
interface sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface : sync_if

// >>> logic/sync2.sv
// two-flop synchroniser for a group of independent bits
// assumes each bit is a level or a toggle; multi-bit words must be held stable
module sync2 #(
   parameter int W = 1
) (
   input wire clk,
   input wire rst,
   sync_if.sync p
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   if ($bits(p.raw) != W)
   begin : g_width_check
      $error("sync2 width does not match its interface");
   end

   always_comb
   begin
      next_st.first = p.raw;
      next_st.second = st.first;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign p.synced = st.second;
endmodule : sync2

// >>> logic/adc_serial_ctrl.sv
// serial control, mode and readout logic of an eight-channel 16-bit converter
// assumes cs_n, serial_clock and serial_in come from the host; analog_code is the
// comparator result of the analog core, held by its sample-and-hold while converting
module adc_serial_ctrl (
   input wire clk,
   input wire rst,
   input wire serial_clock,
   input wire cs_n,
   input wire serial_in,
   input wire [15:0] analog_code,
   output logic serial_out,
   output logic serial_out_oe,
   output logic busy,
   output logic busy_oe,
   output logic [2:0] channel_select,
   output logic single_diff_select,
   output logic acquire,
   output logic power_mode_hi,
   output logic power_mode_lo,
   output logic int_clock_mode,
   output logic low_power
);
   // link side, posedge: frame state, cleared whenever select is high
   typedef struct packed {
      adc_serial_pkg::link_phase_t phase;
      logic [adc_serial_pkg::CNT_W-1:0] cnt;
      logic [5:0] ctrl;
      logic [adc_serial_pkg::RESULT_BITS-1:0] sar;
      logic acquire;
   } frame_t;

   // link side, posedge: hand-off state that must survive select going high
   typedef struct packed {
      logic ctrl_tgl;
      logic [1:0] ctrl_pm;
      logic done_tgl;
      logic ready_seen;
      logic [2:0] chan;
      logic sgl;
   } handoff_t;

   // link side, negedge: pin drive
   typedef struct packed {
      logic dout;
      logic ext_busy;
   } pin_t;

   // system clock side
   typedef struct packed {
      logic clock_int;
      logic auto_pd;
      logic [1:0] pm;
      logic low_power;
      logic conv_active;
      logic [adc_serial_pkg::CONV_CNT_W-1:0] conv_cnt;
      logic [adc_serial_pkg::RESULT_BITS-1:0] hold;
      logic [adc_serial_pkg::RESULT_BITS-1:0] result;
      logic ready_tgl;
      logic ctrl_seen;
      logic done_seen;
      logic busy;
      logic busy_oe;
      logic dout_oe;
   } core_t;

   frame_t fr;
   frame_t next_fr;
   handoff_t hs;
   handoff_t next_hs;
   pin_t pn;
   pin_t next_pn;
   core_t cr;
   core_t next_cr;

   logic frame_rst;
   logic pending;
   logic ctrl_evt;
   logic done_evt;

   sync_if #(.W(4)) core_bits ();
   sync_if #(.W(16)) core_code ();
   sync_if #(.W(2)) link_bits ();
   sync_if #(.W(16)) link_code ();

   if (adc_serial_pkg::INT_CONV_CYCLES > adc_serial_pkg::MAX_BUSY_CYCLES)
   begin : g_conv_check
      $error("internal conversion would hold busy low too long");
   end

   // a high select aborts the frame at once, even with the serial clock stopped
   assign frame_rst = rst | cs_n;

   assign core_bits.raw = {hs.ctrl_tgl, hs.done_tgl, cs_n, pn.ext_busy};
   assign core_code.raw = analog_code;
   assign link_bits.raw = {cr.clock_int, cr.ready_tgl};
   assign link_code.raw = analog_code;

   sync2 #(.W(4)) u_core_bits (
      .clk(clk),
      .rst(rst),
      .p(core_bits)
   );

   sync2 #(.W(16)) u_core_code (
      .clk(clk),
      .rst(rst),
      .p(core_code)
   );

   sync2 #(.W(2)) u_link_bits (
      .clk(serial_clock),
      .rst(rst),
      .p(link_bits)
   );

   sync2 #(.W(16)) u_link_code (
      .clk(serial_clock),
      .rst(rst),
      .p(link_code)
   );

   // ---------------- link domain ----------------
   // a finished internal result is waiting to be shifted out
   assign pending = link_bits.synced[0] != hs.ready_seen;

   always_comb
   begin
      next_fr = fr;
      next_hs = hs;
      unique case (fr.phase)
         adc_serial_pkg::PH_IDLE:
         begin
            if (pending)
            begin
               // result word is stable: it changes only on the next internal conversion
               next_hs.ready_seen = ~hs.ready_seen;
               next_fr.sar = cr.result;
               next_fr.phase = adc_serial_pkg::PH_READ;
               next_fr.cnt = '0;
            end
            else if (serial_in)
            begin
               next_fr.phase = adc_serial_pkg::PH_CTRL;
               next_fr.cnt = adc_serial_pkg::CNT_START;
            end
         end
         adc_serial_pkg::PH_CTRL:
         begin
            next_fr.ctrl = {fr.ctrl[4:0], serial_in};
            next_fr.cnt = fr.cnt + 5'h01;
            if (fr.cnt == adc_serial_pkg::CNT_CHAN_DONE)
               next_hs.chan = {fr.ctrl[1:0], serial_in};
            if (fr.cnt == adc_serial_pkg::CNT_ACQ_START)
               next_fr.acquire = 1'b1;
            if (fr.cnt == adc_serial_pkg::CNT_SGL_BIT)
               next_hs.sgl = serial_in;
            if (fr.cnt == adc_serial_pkg::CNT_BYTE_DONE)
            begin
               // hold starts; the mode used is the one before this byte lands
               next_fr.acquire = 1'b0;
               next_fr.cnt = '0;
               next_fr.sar = link_code.synced;
               next_hs.ctrl_pm = {fr.ctrl[0], serial_in};
               next_hs.ctrl_tgl = ~hs.ctrl_tgl;
               if (link_bits.synced[1])
                  next_fr.phase = adc_serial_pkg::PH_WAIT;
               else
                  next_fr.phase = adc_serial_pkg::PH_CONV;
            end
         end
         adc_serial_pkg::PH_CONV:
         begin
            if (fr.cnt == adc_serial_pkg::CNT_RESULT_DONE)
            begin
               // LSB still on the pin while the next start bit is sampled
               next_fr.phase = serial_in ? adc_serial_pkg::PH_CTRL
                                         : adc_serial_pkg::PH_IDLE;
               next_fr.cnt = serial_in ? adc_serial_pkg::CNT_START : '0;
            end
            else
            begin
               next_fr.cnt = fr.cnt + 5'h01;
               if (fr.cnt != '0)
                  next_fr.sar = {fr.sar[14:0], 1'b0};
               if (fr.cnt == adc_serial_pkg::CNT_LAST_SHIFT)
                  next_hs.done_tgl = ~hs.done_tgl;
            end
         end
         adc_serial_pkg::PH_WAIT:
         begin
            // din ignored until the internal result is in
            if (pending)
            begin
               next_hs.ready_seen = ~hs.ready_seen;
               next_fr.sar = cr.result;
               next_fr.phase = adc_serial_pkg::PH_READ;
               next_fr.cnt = '0;
            end
         end
         adc_serial_pkg::PH_READ:
         begin
            if (fr.cnt == adc_serial_pkg::CNT_LAST_SHIFT)
            begin
               next_fr.phase = serial_in ? adc_serial_pkg::PH_CTRL
                                         : adc_serial_pkg::PH_IDLE;
               next_fr.cnt = serial_in ? adc_serial_pkg::CNT_START : '0;
            end
            else
            begin
               next_fr.sar = {fr.sar[14:0], 1'b0};
               next_fr.cnt = fr.cnt + 5'h01;
            end
         end
      endcase
   end

   // falling-edge pin drive from the frame state
   always_comb
   begin
      next_pn.dout = 1'b0;
      next_pn.ext_busy = 1'b0;
      if (fr.phase == adc_serial_pkg::PH_CONV)
      begin
         next_pn.ext_busy = fr.cnt == '0;
         next_pn.dout = (fr.cnt != '0) && fr.sar[15];
      end
      else if (fr.phase == adc_serial_pkg::PH_READ)
         next_pn.dout = fr.sar[15];
   end

   always_ff @(posedge serial_clock or posedge frame_rst)
   begin
      if (frame_rst)
         fr <= '0;
      else
         fr <= next_fr;
   end

   always_ff @(posedge serial_clock or posedge rst)
   begin
      if (rst)
         hs <= '0;
      else
         hs <= next_hs;
   end

   always_ff @(negedge serial_clock or posedge frame_rst)
   begin
      if (frame_rst)
         pn <= '0;
      else
         pn <= next_pn;
   end

   // ---------------- system clock domain ----------------
   assign ctrl_evt = core_bits.synced[3] != cr.ctrl_seen;
   assign done_evt = core_bits.synced[2] != cr.done_seen;

   always_comb
   begin
      next_cr = cr;
      next_cr.ctrl_seen = core_bits.synced[3];
      next_cr.done_seen = core_bits.synced[2];
      if (cr.conv_active)
      begin
         // keeps running with select high
         next_cr.conv_cnt = cr.conv_cnt + 1'b1;
         if (cr.conv_cnt == adc_serial_pkg::CONV_CNT_W'(adc_serial_pkg::INT_CONV_CYCLES - 1))
         begin
            next_cr.conv_active = 1'b0;
            next_cr.result = cr.hold;
            next_cr.ready_tgl = ~cr.ready_tgl;
            next_cr.low_power = cr.auto_pd;
         end
      end
      if (done_evt)
         next_cr.low_power = cr.auto_pd;
      if (ctrl_evt)
      begin
         // a new byte means a new conversion: power is back at once
         next_cr.low_power = 1'b0;
         if (cr.clock_int)
         begin
            next_cr.conv_active = 1'b1;
            next_cr.conv_cnt = '0;
            next_cr.hold = core_code.synced;
         end
         unique case (hs.ctrl_pm)
            adc_serial_pkg::PM_AUTO_PD:
            begin
               next_cr.auto_pd = 1'b1;
               next_cr.pm = hs.ctrl_pm;
            end
            adc_serial_pkg::PM_INT_CLK:
            begin
               next_cr.auto_pd = 1'b0;
               next_cr.clock_int = 1'b1;
               next_cr.pm = hs.ctrl_pm;
            end
            adc_serial_pkg::PM_EXT_CLK:
            begin
               next_cr.auto_pd = 1'b0;
               next_cr.clock_int = 1'b0;
               next_cr.pm = hs.ctrl_pm;
            end
            adc_serial_pkg::PM_RESERVED:
            begin
               next_cr.pm = cr.pm;
            end
         endcase
      end
      // busy follows a running internal conversion, whatever the new mode; the external busy only while in external mode
      if (next_cr.clock_int || next_cr.conv_active || cr.conv_active)
      begin
         next_cr.busy = ~next_cr.conv_active;
         next_cr.busy_oe = 1'b1;
      end
      else
      begin
         next_cr.busy = core_bits.synced[0];
         next_cr.busy_oe = ~core_bits.synced[1];
      end
      next_cr.dout_oe = ~core_bits.synced[1];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cr <= '0;
      else
         cr <= next_cr;
   end

   assign serial_out = pn.dout;
   assign serial_out_oe = cr.dout_oe;
   assign busy = cr.busy;
   assign busy_oe = cr.busy_oe;
   assign channel_select = hs.chan;
   assign single_diff_select = hs.sgl;
   assign acquire = fr.acquire;
   assign power_mode_hi = cr.pm[1];
   assign power_mode_lo = cr.pm[0];
   assign int_clock_mode = cr.clock_int;
   assign low_power = cr.low_power;
endmodule : adc_serial_ctrl

// >>> dv/adc_serial_ctrl_properties.sv
// port relations of the converter control block, clk domain only
// assumes binding onto adc_serial_ctrl
module adc_serial_ctrl_properties (
   input wire clk,
   input wire rst,
   input wire cs_n,
   input logic busy,
   input logic busy_oe,
   input logic serial_out_oe,
   input logic [2:0] channel_select,
   input logic acquire,
   input logic power_mode_hi,
   input logic power_mode_lo,
   input logic int_clock_mode,
   input logic low_power
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_NO_RESERVED: assert property (!(!power_mode_hi && power_mode_lo))
      else $error("reserved power code accepted");
   AST_SDO_FLOATS: assert property (cs_n [*4] |-> !serial_out_oe)
      else $error("data out driven while deselected");
   AST_EXT_BUSY_FLOATS: assert property ((cs_n && !int_clock_mode) [*4] |-> !busy_oe)
      else $error("busy driven while deselected");
   AST_INT_BUSY_DRIVEN: assert property (int_clock_mode [*4] |-> busy_oe)
      else $error("busy floats in internal mode");
   AST_INT_BUSY_BOUND: assert property ($fell(busy) && int_clock_mode |-> ##[1:200] busy)
      else $error("internal conversion too long");
   AST_LOW_POWER_AUTO: assert property ($rose(low_power) |-> !power_mode_hi && !power_mode_lo)
      else $error("low power outside auto mode");
   AST_CHAN_HELD: assert property ($past(acquire) && acquire |-> $stable(channel_select))
      else $error("channel moved while sampling");
   AST_MODE_CODE: assert property ((power_mode_hi && $stable(power_mode_lo)) [*4]
      |-> int_clock_mode == !power_mode_lo)
      else $error("clock mode does not follow code");
   COV_INT_CONV: cover property ($fell(busy) && int_clock_mode);
   COV_LOW_POWER: cover property ($rose(low_power));
   COV_SELECT: cover property ($rose(serial_out_oe));
   COV_ACQUIRE: cover property ($rose(acquire));
endmodule : adc_serial_ctrl_properties

bind adc_serial_ctrl adc_serial_ctrl_properties i_adc_serial_ctrl_properties (
   .clk(clk), .rst(rst), .cs_n(cs_n), .busy(busy), .busy_oe(busy_oe),
   .serial_out_oe(serial_out_oe), .channel_select(channel_select), .acquire(acquire),
   .power_mode_hi(power_mode_hi), .power_mode_lo(power_mode_lo),
   .int_clock_mode(int_clock_mode), .low_power(low_power));

// >>> dv/host_model.sv
// host serial port model: select, serial clock and data toward the converter
// assumes data out settles within half a serial clock after a falling edge
module host_model (
   input wire clk,
   input wire serial_out,
   input wire serial_out_oe,
   output logic serial_clock,
   output logic cs_n,
   output logic serial_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sdo_last;
   logic sdo_line;
   // released line shows the inverse so a stale bit never passes
   assign sdo_line = serial_out_oe ? serial_out : ~sdo_last;
   always @(negedge serial_clock)
      if (serial_out_oe)
         sdo_last <= serial_out;
   initial
   begin
      serial_clock = 1'h0;
      cs_n = 1'h1;
      serial_in = 1'h0;
      sdo_last = 1'h0;
   end
   task automatic select(input logic v);
      @(posedge clk);
      cs_n <= v;
      repeat (4) @(posedge clk);
   endtask : select
   // 30 ns clock only inside a stream, resting low between
   // well above 2.4 MHz; logic only, so no acquisition_interval floor applies
   task automatic stream(input logic [63:0] din, input int n, output logic [63:0] dout);
      dout = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in = din[i];
         #15;
         dout = {dout[62:0], sdo_line};
         serial_clock = 1'h1;
         #15;
         serial_clock = 1'h0;
      end
      serial_in = 1'h0;
   endtask : stream
endmodule : host_model

// >>> dv/test_adc_serial_ctrl.sv
// self-checking bench of the converter control block
// assumes the host model drives the serial side and the bench the analog code
module test_adc_serial_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst;
   logic [15:0] analog_code;
   wire serial_clock;
   wire cs_n;
   wire serial_in;
   logic serial_out, serial_out_oe, busy, busy_oe, acquire, single_diff_select;
   logic power_mode_hi, power_mode_lo, int_clock_mode, low_power;
   logic [2:0] channel_select;
   logic [63:0] got;
   int err_count;
   int n_tests;

   adc_serial_ctrl i_adc_serial_ctrl (.clk(clk), .rst(rst), .serial_clock(serial_clock),
      .cs_n(cs_n), .serial_in(serial_in), .analog_code(analog_code),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe), .busy(busy),
      .busy_oe(busy_oe), .channel_select(channel_select),
      .single_diff_select(single_diff_select), .acquire(acquire),
      .power_mode_hi(power_mode_hi), .power_mode_lo(power_mode_lo),
      .int_clock_mode(int_clock_mode), .low_power(low_power));
   host_model i_host_model (.clk(clk), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .serial_clock(serial_clock), .cs_n(cs_n),
      .serial_in(serial_in));

   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
      n_tests++;
      if (got_v !== exp_v)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask : check

   task automatic finish_test();
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic ext_read_25();
      @(posedge clk) analog_code <= 16'ha5c3;
      // idle zeros ahead of the start bit
      i_host_model.stream({3'h0, 8'hd7, 17'h0}, 28, got);
      check(got[15:0], 16'ha5c3);
      repeat (6) @(posedge clk);
      check({channel_select, single_diff_select}, 4'hb);
      check({power_mode_hi, power_mode_lo, int_clock_mode}, 3'h6);
   endtask : ext_read_25

   task automatic ext_read_32();
      @(posedge clk) analog_code <= 16'h8001;
      i_host_model.stream({8'ha3, 24'h0}, 32, got);
      check(got[22:0], {16'h8001, 7'h0});
      check({channel_select, single_diff_select}, 4'h4);
   endtask : ext_read_32

   task automatic ext_overlap_24();
      @(posedge clk) analog_code <= 16'h7ffe;
      i_host_model.stream({8'hd7, 16'h0, 8'hd7, 17'h0}, 49, got);
      check(got[39:24], 16'h7ffe);
      check(got[15:0], 16'h7ffe);
   endtask : ext_overlap_24

   task automatic ext_cs_float();
      i_host_model.select(1'h1);
      check({serial_out_oe, busy_oe}, 2'h0);
      i_host_model.select(1'h0);
      check({busy_oe, busy}, 2'h2);
   endtask : ext_cs_float

   task automatic auto_power_down();
      @(posedge clk) analog_code <= 16'h0000;
      i_host_model.stream({8'h94, 17'h0}, 25, got);
      check(got[15:0], 16'h0000);
      repeat (6) @(posedge clk);
      check({low_power, int_clock_mode, power_mode_hi, power_mode_lo}, 4'h8);
      @(posedge clk) analog_code <= 16'hc33c;
      i_host_model.stream({8'hd7, 17'h0}, 25, got);
      check(got[15:0], 16'hc33c);
      repeat (6) @(posedge clk);
      check(low_power, 1'h0);
   endtask : auto_power_down

   task automatic reserved_code();
      i_host_model.stream({8'h95, 17'h0}, 25, got);
      repeat (6) @(posedge clk);
      check({power_mode_hi, power_mode_lo, int_clock_mode}, 3'h6);
   endtask : reserved_code

   task automatic internal_mode();
      int t;
      @(posedge clk) analog_code <= 16'h5aa5;
      i_host_model.stream({8'h96, 17'h0}, 25, got);
      check(got[15:0], 16'h5aa5);
      repeat (6) @(posedge clk);
      check(int_clock_mode, 1'h1);
      @(posedge clk) analog_code <= 16'h3cc3;
      i_host_model.stream(64'h96, 8, got);
      i_host_model.select(1'h1);
      check({busy, busy_oe, serial_out_oe}, 3'h2);
      t = 0;
      while (busy !== 1'h1 && t < 400)
      begin
         @(posedge clk);
         t++;
      end
      check({busy, busy_oe, serial_out_oe, t < 200}, 4'hd);
      // readout clock stopped a while before reading
      repeat (50) @(posedge clk);
      i_host_model.select(1'h0);
      // two rises to see the result, one to load it, then sixteen bits
      i_host_model.stream(64'h0, 19, got);
      check(got[16:0], {1'h0, 16'h3cc3});
   endtask : internal_mode

   initial
   begin
      rst = 1'h1;
      analog_code = 16'h0000;
      err_count = 0;
      n_tests = 0;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      i_host_model.select(1'h0);
      ext_read_25();
      ext_read_32();
      ext_overlap_24();
      ext_cs_float();
      auto_power_down();
      reserved_code();
      internal_mode();
      finish_test();
   end

   initial
   begin
      #400_000;
      err_count++;
      finish_test();
   end
endmodule : test_adc_serial_ctrl
